// ### rtl/bsr_buf2.sv
`timescale 1ns/1ps
module bsr_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             CLK_SYS,
  input  wire logic             RESETN,
  // Filling side
  input  wire logic             IN_VALID,
  output logic                  IN_READY,
  input  wire logic [WIDTH-1:0] IN_DATA,
  // Draining side
  output logic                  OUT_VALID,
  input  wire logic             OUT_READY,
  output logic      [WIDTH-1:0] OUT_DATA
);

  localparam int PW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("bsr_buf2: DEPTH must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wr_ptr_ff;
  logic [PW-1:0]    rd_ptr_ff;
  logic [PW:0]      cnt_ff;
  wire              push = IN_VALID && IN_READY;
  wire              pop  = OUT_VALID && OUT_READY;

  assign IN_READY  = (cnt_ff != (PW+1)'(DEPTH));
  assign OUT_VALID = (cnt_ff != '0);
  assign OUT_DATA  = mem_ff[rd_ptr_ff];

  always_ff @(posedge CLK_SYS) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= IN_DATA;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + PW'(push);
      rd_ptr_ff <= rd_ptr_ff + PW'(pop);
      cnt_ff    <= cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule

// ### rtl/bsr_pkg.sv
package bsr_pkg;

  // ---------------------------------------------------------------
  // Shape of the shift chain
  // ---------------------------------------------------------------
  localparam int          NUM_STAGES   = 8;
  localparam int          TAP_W        = 3;
  localparam logic [2:0]  TAP_FIRST    = 3'h0;
  localparam logic [2:0]  TAP_LAST     = 3'h7;
  localparam logic [7:0]  STAGE_CLEAR  = 8'h00;

  // ---------------------------------------------------------------
  // Register bus layout
  // ---------------------------------------------------------------
  localparam int          ADR_W        = 8;
  localparam int          DAT_W        = 32;
  localparam logic [7:0]  ADR_CFG      = 8'h00;
  localparam logic [7:0]  ADR_STAT     = 8'h04;

  // CFG fields
  localparam int          CFG_TAP_LSB  = 0;
  localparam int          CFG_RETAIN   = 3;
  localparam int          CFG_RUN      = 4;

  // STAT fields
  localparam int          STAT_STG_LSB = 0;
  localparam int          STAT_PEND    = 8;
  localparam int          STAT_OVALID  = 9;
  localparam int          STAT_DIR     = 10;

  // Reset values
  localparam logic        RUN_RST      = 1'b1;
  localparam logic [31:0] DAT_ZERO     = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Snapshot stream buffer
  // ---------------------------------------------------------------
  localparam int          BUF_DEPTH    = 2;

endpackage

// ### rtl/bsr_top.sv
// What this block does
// - A rising trigger while running samples the source bit and shifts once; one arriving while a shift is held pending is merged into it.
// - Direction low: sampled bit enters stage one, others move up one.
// - Direction high: sampled bit enters stage eight, others move down one.
// - Output shows the one configured stage, first through last, from the first clock after reset; it is low while in reset.
// - Without retention, restart after power loss from the initial state.
// - With retention, all eight stages survive power loss together.
// - Tap and retention settings cannot change while running.
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module bsr_top
  import bsr_pkg::*;
#(
  parameter logic [2:0] TAP_INIT    = bsr_pkg::TAP_FIRST,
  parameter logic       RETAIN_INIT = 1'b0
) (
  // Clock and reset
  input  wire logic                       CLK_SYS,
  input  wire logic                       RESETN,
  // Program logic side
  input  wire logic                       SRC_IN,
  input  wire logic                       TRG_IN,
  input  wire logic                       DIR_IN,
  output logic                            STAGE_Q,
  // Snapshot stream
  output logic                            SNAP_VALID,
  input  wire logic                       SNAP_READY,
  output logic [bsr_pkg::NUM_STAGES-1:0]  SNAP_DATA,
  // Wishbone slave
  input  wire logic                       WB_CYC_I,
  input  wire logic                       WB_STB_I,
  input  wire logic                       WB_WE_I,
  input  wire logic [bsr_pkg::ADR_W-1:0]  WB_ADR_I,
  input  wire logic [3:0]                 WB_SEL_I,
  input  wire logic [bsr_pkg::DAT_W-1:0]  WB_DAT_I,
  output logic [bsr_pkg::DAT_W-1:0]       WB_DAT_O,
  output logic                            WB_ACK_O,
  output logic                            WB_ERR_O
);

  import bsr_pkg::*;

  initial begin
    if (NUM_STAGES != 8) begin
      $error("bsr_top: chain is built for eight stages");
    end
  end

  // ---------------------------------------------------------------
  // Cycle sampling of program inputs
  // ---------------------------------------------------------------
  logic                   src_ff;
  logic                   trg_ff;
  logic                   dir_ff;
  logic                   trg_prev_ff;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      src_ff      <= 1'b0;
      trg_ff      <= 1'b0;
      dir_ff      <= 1'b0;
      trg_prev_ff <= 1'b0;
    end else begin
      src_ff      <= SRC_IN;
      trg_ff      <= TRG_IN;
      dir_ff      <= DIR_IN;
      trg_prev_ff <= trg_ff;
    end
  end

  // ---------------------------------------------------------------
  // Configuration and run state
  // ---------------------------------------------------------------
  logic [TAP_W-1:0]       tap_ff;
  logic                   retain_ff;
  logic                   run_ff;
  logic                   start_ff;

  // ---------------------------------------------------------------
  // Edge detection and pending shift
  // ---------------------------------------------------------------
  // Held while the buffer is full so an edge is never lost;
  // further edges during the stall are merged into it.
  logic                   pend_ff;
  logic                   pend_src_ff;
  logic                   pend_dir_ff;
  logic                   buf_ready;

  wire trg_rise  = trg_ff && !trg_prev_ff;
  wire take      = pend_ff || (trg_rise && run_ff);
  wire sh_src    = pend_ff ? pend_src_ff : src_ff;
  wire sh_dir    = pend_ff ? pend_dir_ff : dir_ff;
  wire do_shift  = take && buf_ready;
  wire nxt_pend  = take && !buf_ready;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pend_ff     <= 1'b0;
      pend_src_ff <= 1'b0;
      pend_dir_ff <= 1'b0;
    end else begin
      pend_ff     <= nxt_pend;
      pend_src_ff <= sh_src;
      pend_dir_ff <= sh_dir;
    end
  end

  // ---------------------------------------------------------------
  // Shift chain
  // ---------------------------------------------------------------
  // Stage flops have no reset: retention keeps them across RESETN.
  // Power-on contents come from the configuration load, not from reset.
  logic [NUM_STAGES-1:0]  stage_ff = STAGE_CLEAR;
  logic [NUM_STAGES-1:0]  nxt_stage_ff;
  wire  [NUM_STAGES-1:0]  up_val   = {stage_ff[NUM_STAGES-2:0], sh_src};
  wire  [NUM_STAGES-1:0]  down_val = {sh_src, stage_ff[NUM_STAGES-1:1]};
  wire  [NUM_STAGES-1:0]  shifted  = sh_dir ? down_val : up_val;

  assign nxt_stage_ff = (start_ff && !retain_ff) ? STAGE_CLEAR :
                        start_ff                 ? stage_ff :
                        do_shift                 ? shifted  :
                                                   stage_ff;

  always_ff @(posedge CLK_SYS) begin
    stage_ff <= nxt_stage_ff;
  end

  // ---------------------------------------------------------------
  // Tap output
  // ---------------------------------------------------------------
  function automatic logic tap_pick(input logic [NUM_STAGES-1:0] s,
                                    input logic [TAP_W-1:0]      t);
    tap_pick = s[t];
  endfunction

  logic                   q_ff;
  logic [TAP_W-1:0]       nxt_tap_ff;
  wire                    nxt_q_ff = tap_pick(nxt_stage_ff, nxt_tap_ff);

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      q_ff <= 1'b0;
    end else begin
      q_ff <= nxt_q_ff;
    end
  end

  assign STAGE_Q = q_ff;

  // ---------------------------------------------------------------
  // Snapshot buffer
  // ---------------------------------------------------------------
  bsr_buf2 #(
    .WIDTH (NUM_STAGES),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .CLK_SYS   (CLK_SYS),
    .RESETN    (RESETN),
    .IN_VALID  (do_shift),
    .IN_READY  (buf_ready),
    .IN_DATA   (shifted),
    .OUT_VALID (SNAP_VALID),
    .OUT_READY (SNAP_READY),
    .OUT_DATA  (SNAP_DATA)
  );

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  logic                   ack_ff;
  logic                   err_ff;
  logic [DAT_W-1:0]       dat_ff;

  wire req      = WB_CYC_I && WB_STB_I && !ack_ff && !err_ff;
  wire hit_cfg  = (WB_ADR_I == ADR_CFG);
  wire hit_stat = (WB_ADR_I == ADR_STAT);
  wire hit      = hit_cfg || hit_stat;
  wire cfg_wr   = req && hit_cfg && WB_WE_I && WB_SEL_I[0];
  // Locked settings: a write while running only touches the run bit.
  wire cfg_lock = run_ff;
  wire [DAT_W-1:0] cfg_word = {27'h000_0000, run_ff, retain_ff, tap_ff};
  wire [DAT_W-1:0] stat_word = {21'h00_0000, pend_ff ? pend_dir_ff : dir_ff,
                                SNAP_VALID, pend_ff, stage_ff};
  wire [DAT_W-1:0] rd_word  = hit_cfg  ? cfg_word :
                              hit_stat ? stat_word : DAT_ZERO;

  assign nxt_tap_ff = (cfg_wr && !cfg_lock) ?
                      WB_DAT_I[CFG_TAP_LSB +: TAP_W] : tap_ff;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
      dat_ff <= DAT_ZERO;
    end else begin
      ack_ff <= req && hit;
      err_ff <= req && !hit;
      dat_ff <= (req && !WB_WE_I) ? rd_word : DAT_ZERO;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      tap_ff    <= TAP_INIT;
      retain_ff <= RETAIN_INIT;
      run_ff    <= RUN_RST;
      start_ff  <= 1'b1;
    end else begin
      start_ff <= 1'b0;
      tap_ff   <= nxt_tap_ff;
      if (cfg_wr && !cfg_lock) begin
        retain_ff <= WB_DAT_I[CFG_RETAIN];
      end
      if (cfg_wr) begin
        run_ff <= WB_DAT_I[CFG_RUN];
      end
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_ERR_O = err_ff;
  assign WB_DAT_O = dat_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_rise_loads;
    @(posedge CLK_SYS) disable iff (!RESETN)
      (trg_rise && run_ff && !pend_ff && buf_ready && !start_ff) |=>
        ($past(dir_ff) ? stage_ff[NUM_STAGES-1] : stage_ff[0]) == $past(src_ff);
  endproperty
  a_rise_loads: assert property (p_rise_loads)
    else $error("rising trigger did not load the source bit");

  property p_fall_quiet;
    @(posedge CLK_SYS) disable iff (!RESETN)
      (!trg_rise && !pend_ff && !start_ff) |=> $stable(stage_ff);
  endproperty
  a_fall_quiet: assert property (p_fall_quiet)
    else $error("stages changed without a rising trigger");

  property p_shift_up;
    @(posedge CLK_SYS) disable iff (!RESETN)
      (do_shift && !sh_dir && !start_ff) |=>
        stage_ff == {$past(stage_ff[NUM_STAGES-2:0]), $past(sh_src)};
  endproperty
  a_shift_up: assert property (p_shift_up)
    else $error("upward shift wrong");

  property p_shift_down;
    @(posedge CLK_SYS) disable iff (!RESETN)
      (do_shift && sh_dir && !start_ff) |=>
        stage_ff == {$past(sh_src), $past(stage_ff[NUM_STAGES-1:1])};
  endproperty
  a_shift_down: assert property (p_shift_down)
    else $error("downward shift wrong");

  property p_tap_out;
    @(posedge CLK_SYS) disable iff (!RESETN)
      !start_ff |-> STAGE_Q == stage_ff[tap_ff];
  endproperty
  a_tap_out: assert property (p_tap_out)
    else $error("output does not follow the tapped stage");

  property p_clear_start;
    @(posedge CLK_SYS) disable iff (!RESETN)
      (start_ff && !retain_ff) |=> (stage_ff == STAGE_CLEAR) && !STAGE_Q;
  endproperty
  a_clear_start: assert property (p_clear_start)
    else $error("stages not cleared at power-up");

  property p_keep_start;
    @(posedge CLK_SYS) disable iff (!RESETN)
      (start_ff && retain_ff) |=> stage_ff == $past(stage_ff);
  endproperty
  a_keep_start: assert property (p_keep_start)
    else $error("retained stages lost at power-up");

  property p_cfg_locked;
    @(posedge CLK_SYS) disable iff (!RESETN)
      (run_ff && cfg_wr) |=> $stable(tap_ff) && $stable(retain_ff);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked)
    else $error("settings changed while running");

  property p_pend_held;
    @(posedge CLK_SYS) disable iff (!RESETN)
      (take && !buf_ready) |=>
        pend_ff && (sh_src == $past(sh_src)) && (sh_dir == $past(sh_dir));
  endproperty
  a_pend_held: assert property (p_pend_held)
    else $error("stalled edge was not held");

endmodule

// ### verification/bsr_prog_model.sv
`timescale 1ns/1ps
module bsr_prog_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Trigger side
  output logic            src,
  output logic            trg,
  output logic            dir,
  // Snapshot side
  input  wire logic       stall,
  input  wire logic       snap_valid,
  output logic            snap_ready,
  input  wire logic [7:0] snap_data
);
  logic [7:0] got_q[$];

  initial begin
    src = 1'b0;
    trg = 1'b0;
    dir = 1'b0;
  end

  // Consumer may stall at will
  assign snap_ready = !stall;

  always @(posedge clk) begin
    if (rst_n && snap_valid && snap_ready) begin
      got_q.push_back(snap_data);
    end
  end

  // Source and direction held while trigger is sampled high, then a low gap
  task automatic shift(input logic s, input logic d);
    @(posedge clk);
    src <= s;
    dir <= d;
    trg <= 1'b1;
    repeat (2) @(posedge clk);
    trg <= 1'b0;
    src <= ~s;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ### verification/bsr_top_tb.sv
`timescale 1ns/1ps
module bsr_top_tb;
  import bsr_pkg::*;

  logic             clk_sys, resetn, stall, cyc, stb, we;
  logic [ADR_W-1:0] adr;
  logic [3:0]       sel;
  logic [DAT_W-1:0] wdat, rdat, rdat_r, rd, rd_r;
  logic             ack, err, er, src, trg, dir, q, q_r, svalid, sready;
  logic [7:0]       sdata, exp_st;
  logic [7:0]       exp_q[$];
  int               fail_count;
  int               n_tests;

  bsr_top dut_u (.CLK_SYS(clk_sys), .RESETN(resetn), .SRC_IN(src), .TRG_IN(trg),
    .DIR_IN(dir), .STAGE_Q(q), .SNAP_VALID(svalid), .SNAP_READY(sready),
    .SNAP_DATA(sdata), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .WB_ERR_O(err));
  // Retentive twin sees the same stimulus
  bsr_top #(.RETAIN_INIT(1'b1)) dut_r (.CLK_SYS(clk_sys), .RESETN(resetn),
    .SRC_IN(src), .TRG_IN(trg), .DIR_IN(dir), .STAGE_Q(q_r), .SNAP_VALID(),
    .SNAP_READY(sready), .SNAP_DATA(), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat_r), .WB_ACK_O(),
    .WB_ERR_O());
  bsr_prog_model prog_u (.clk(clk_sys), .rst_n(resetn), .src(src), .trg(trg), .dir(dir),
    .stall(stall), .snap_valid(svalid), .snap_ready(sready), .snap_data(sdata));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_sys);
    end while (ack !== 1'b1 && err !== 1'b1);
    rd = rdat;
    rd_r = rdat_r;
    er = err;
    check("bus answer", 1, ack ^ err);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic pulse(input logic s, input logic d);
    prog_u.shift(s, d);
    exp_st = d ? {s, exp_st[7:1]} : {exp_st[6:0], s};
    exp_q.push_back(exp_st);
    wb(1'b0, ADR_STAT, 0);
    check("stages", exp_st, rd[7:0]);
  endtask

  task automatic check_snaps();
    repeat (4) @(posedge clk_sys);
    check("snap count", exp_q.size(), prog_u.got_q.size());
    while (exp_q.size() > 0 && prog_u.got_q.size() > 0) begin
      check("snap", exp_q.pop_front(), prog_u.got_q.pop_front());
    end
    exp_q.delete();
    prog_u.got_q.delete();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    wb(1'b0, ADR_CFG, 0);
    check("cfg reset", 32'h0000_0010, rd);
    check("cfg reset twin", 32'h0000_0018, rd_r);
    wb(1'b0, ADR_STAT, 0);
    check("stat reset", 32'h0000_0000, rd);
    check("tap out", 0, q);
  endtask

  task automatic t_up();
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b0);
    pulse(1'b1, 1'b0);
    pulse(1'b1, 1'b0);
    check("tap out", exp_st[0], q);
    check_snaps();
  endtask

  task automatic t_down();
    pulse(1'b1, 1'b1);
    pulse(1'b0, 1'b1);
    pulse(1'b0, 1'b0);
    pulse(1'b1, 1'b1);
    pulse(1'b1, 1'b1);
    check_snaps();
  endtask

  // Full buffer holds the third shift back instead of losing it
  task automatic t_buffer();
    stall <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      prog_u.shift(i[0], 1'b0);
      exp_st = {exp_st[6:0], i[0]};
      exp_q.push_back(exp_st);
    end
    wb(1'b0, ADR_STAT, 0);
    check("stat stalled", {3'b011, exp_q[1]}, rd[10:0]);
    stall <= 1'b0;
    repeat (6) @(posedge clk_sys);
    wb(1'b0, ADR_STAT, 0);
    check("stat drained", {1'b0, exp_st}, rd[8:0]);
    check_snaps();
  endtask

  task automatic t_tap();
    for (int t = 0; t < 8; t++) begin
      wb(1'b1, ADR_CFG, t);
      wb(1'b1, ADR_CFG, 32'h10 | t);
      wb(1'b1, ADR_CFG, 32'h10 | ((t + 1) % 8));
      wb(1'b0, ADR_CFG, 0);
      check("cfg locked", 32'h10 | t, rd);
      check("tap out", exp_st[t], q);
    end
    wb(1'b1, ADR_CFG, 0);
    prog_u.shift(~exp_st[0], 1'b0);
    wb(1'b1, ADR_STAT, 32'hffff_ffff);
    wb(1'b0, ADR_STAT, 0);
    check("stopped stages", exp_st, rd[7:0]);
    wb(1'b1, ADR_CFG, 32'h10);
    wb(1'b0, 8'h08, 0);
    check("unmapped err", 1, er);
  endtask

  task automatic t_retain();
    do_reset();
    wb(1'b0, ADR_STAT, 0);
    check("cleared", 0, rd[7:0]);
    check("kept", exp_st, rd_r[7:0]);
    check("kept tap", exp_st[0], q_r);
    exp_st = 8'h00;
    pulse(1'b1, 1'b1);
    check_snaps();
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    stall = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h0000_0000;
    exp_st = 8'h00;
    fail_count = 0;
    n_tests = 0;
    do_reset();
    t_reset();
    t_up();
    t_down();
    t_buffer();
    t_tap();
    t_retain();
    wrap_up();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    wrap_up();
  end
endmodule
